// *** hdl/irq_enable_level_regs.sv ***
// file: interrupt enable and priority level registers with request gating
`timescale 1ns/100ps
module irq_enable_level_regs (
  input  wire logic                   mclk_in,
  input  wire logic                   rstn_in,
  input  wire logic                   can_present_in,
  input  wire logic [4:0]             addr_in,
  input  wire logic [15:0]            wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  input  wire logic [95:0]            src_flag_in,
  output logic      [15:0]            rdata_out,
  output logic      [95:0]            en_req_out,
  output logic      [7:0]             lvl_req_out,
  output logic      [23:0]            lvl_out,
  output logic                        irq_out
);

  // ----------------------------------------------------------------
  // reset and input synchronisers
  // ----------------------------------------------------------------
  logic        rst_meta_r;
  logic        rst_sync_r;
  logic        can_meta_r;
  logic        can_sync_r;
  logic [95:0] flag_meta_r;
  logic [95:0] flag_sync_r;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      can_meta_r  <= 1'b0;
      can_sync_r  <= 1'b0;
      flag_meta_r <= '0;
      flag_sync_r <= '0;
    end else begin
      can_meta_r  <= can_present_in;
      can_sync_r  <= can_meta_r;
      flag_meta_r <= src_flag_in;
      flag_sync_r <= flag_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // bus request carrier
  // ----------------------------------------------------------------
  irq_regs_pkg::bus_req_t bus;

  always_comb begin
    bus.wr    = wr_in;
    bus.rd    = rd_in;
    bus.addr  = addr_in;
    bus.wdata = wdata_in;
  end

  // ----------------------------------------------------------------
  // enable words
  // ----------------------------------------------------------------
  logic [15:0] en_r [irq_regs_pkg::NUM_EN_WORDS];
  logic [15:0] en_mask [irq_regs_pkg::NUM_EN_WORDS];
  logic [4:0]  en_off  [irq_regs_pkg::NUM_EN_WORDS];

  always_comb begin
    en_mask[0] = irq_regs_pkg::MASK_EN2;
    en_mask[1] = irq_regs_pkg::MASK_EN3;
    en_mask[2] = irq_regs_pkg::MASK_EN4;
    en_mask[3] = irq_regs_pkg::MASK_EN5;
    en_mask[4] = irq_regs_pkg::MASK_EN6;
    en_mask[5] = irq_regs_pkg::MASK_EN7;
    en_off[0]  = irq_regs_pkg::OFF_EN2;
    en_off[1]  = irq_regs_pkg::OFF_EN3;
    en_off[2]  = irq_regs_pkg::OFF_EN4;
    en_off[3]  = irq_regs_pkg::OFF_EN5;
    en_off[4]  = irq_regs_pkg::OFF_EN6;
    en_off[5]  = irq_regs_pkg::OFF_EN7;
  end

  genvar gw;
  generate
    for (gw = 0; gw < irq_regs_pkg::NUM_EN_WORDS; gw++) begin : g_en
      always_ff @(posedge mclk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
          en_r[gw] <= irq_regs_pkg::RST_EN;
        end else if (bus.wr && bus.addr == en_off[gw]) begin
          en_r[gw] <= bus.wdata & en_mask[gw];
        end
      end
    end
  endgenerate

  // named views of the enable bits the block cares about most
  logic i2c_a_master_evt_en;
  logic i2c_a_slave_evt_en;
  logic can_event_en;
  logic can_rx_data_en;
  logic can_tx_data_en;

  always_comb begin
    i2c_a_master_evt_en = en_r[0][1];
    i2c_a_slave_evt_en  = en_r[0][0];
    can_event_en        = en_r[0][3];
    can_rx_data_en      = en_r[0][2];
    can_tx_data_en      = en_r[2][6];
  end

  // effective enables: can bits forced off on variants without can
  logic [15:0] en_eff [irq_regs_pkg::NUM_EN_WORDS];

  always_comb begin
    for (int i = 0; i < irq_regs_pkg::NUM_EN_WORDS; i++) begin
      en_eff[i] = en_r[i];
    end
    if (!can_sync_r) begin
      en_eff[0] = en_r[0] & ~irq_regs_pkg::CAN_EN2;
      en_eff[2] = en_r[2] & ~irq_regs_pkg::CAN_EN4;
    end
  end

  // ----------------------------------------------------------------
  // level words
  // ----------------------------------------------------------------
  logic [15:0] lvl0_r;
  logic [15:0] lvl1_r;

  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      lvl0_r <= irq_regs_pkg::RST_LVL;
      lvl1_r <= irq_regs_pkg::RST_LVL;
    end else if (bus.wr && bus.addr == irq_regs_pkg::OFF_LVL0) begin
      lvl0_r <= bus.wdata & irq_regs_pkg::MASK_LVL;
    end else if (bus.wr && bus.addr == irq_regs_pkg::OFF_LVL1) begin
      lvl1_r <= bus.wdata & irq_regs_pkg::MASK_LVL;
    end
  end

  // ----------------------------------------------------------------
  // request forming
  // ----------------------------------------------------------------
  logic [95:0] en_req_nxt;

  genvar gs;
  generate
    for (gs = 0; gs < irq_regs_pkg::NUM_EN_SRC; gs++) begin : g_src
      assign en_req_nxt[gs] = flag_sync_r[gs] & en_eff[gs / 16][gs % 16];
    end
  endgenerate

  // level sources: bit 0..3 from level word 0, 4..7 from word 1, field k at 4*(k%4)
  irq_regs_pkg::lvl_req_t lreq [irq_regs_pkg::NUM_LVL_SRC];
  logic [7:0]             lvl_en;

  // level sources borrow flag bits 80..87 (enable 7 region); their enable is tied high
  genvar gl;
  generate
    for (gl = 0; gl < irq_regs_pkg::NUM_LVL_SRC; gl++) begin : g_lvl
      assign lvl_en[gl] = 1'b1;
      level_gate u_gate (
        .flag_in  (flag_sync_r[80 + gl]),
        .en_in    (lvl_en[gl]),
        .level_in (gl < 4 ? lvl0_r[4*(gl%4) +: 3] : lvl1_r[4*(gl%4) +: 3]),
        .req_out  (lreq[gl])
      );
    end
  endgenerate

  logic [7:0]  lvl_req_nxt;
  logic [23:0] lvl_nxt;

  always_comb begin
    for (int i = 0; i < irq_regs_pkg::NUM_LVL_SRC; i++) begin
      lvl_req_nxt[i]     = lreq[i].req;
      lvl_nxt[3*i +: 3]  = lreq[i].level;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      en_req_out  <= '0;
      lvl_req_out <= '0;
      lvl_out     <= '0;
    end else begin
      en_req_out  <= en_req_nxt;
      lvl_req_out <= lvl_req_nxt;
      lvl_out     <= lvl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // event status, mask and interrupt
  // ----------------------------------------------------------------
  logic [1:0]  stat_r;
  logic [1:0]  mask_r;
  logic        any_req_r;
  logic        any_req;
  logic        blocked;
  logic [1:0]  evt;

  always_comb begin
    any_req = |en_req_nxt;
    blocked = |(flag_sync_r & ~en_req_nxt);
    evt     = '0;
    evt[irq_regs_pkg::EVT_REQ_RISE] = any_req & ~any_req_r;
    evt[irq_regs_pkg::EVT_BLOCKED]  = blocked;
  end

  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      any_req_r <= 1'b0;
      stat_r    <= '0;
      mask_r    <= '0;
    end else begin
      any_req_r <= any_req;
      // set wins over a write-one clear in the same cycle
      if (bus.wr && bus.addr == irq_regs_pkg::OFF_STAT) begin
        stat_r <= (stat_r & ~bus.wdata[1:0]) | evt;
      end else begin
        stat_r <= stat_r | evt;
      end
      if (bus.wr && bus.addr == irq_regs_pkg::OFF_MASK) begin
        mask_r <= bus.wdata[1:0];
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(stat_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  logic [15:0] rdata_nxt;

  always_comb begin
    rdata_nxt = '0;
    if (bus.addr == irq_regs_pkg::OFF_EN2) begin
      rdata_nxt = en_r[0];
    end else if (bus.addr == irq_regs_pkg::OFF_EN3) begin
      rdata_nxt = en_r[1];
    end else if (bus.addr == irq_regs_pkg::OFF_EN4) begin
      rdata_nxt = en_r[2];
    end else if (bus.addr == irq_regs_pkg::OFF_EN5) begin
      rdata_nxt = en_r[3];
    end else if (bus.addr == irq_regs_pkg::OFF_EN6) begin
      rdata_nxt = en_r[4];
    end else if (bus.addr == irq_regs_pkg::OFF_EN7) begin
      rdata_nxt = en_r[5];
    end else if (bus.addr == irq_regs_pkg::OFF_LVL0) begin
      rdata_nxt = lvl0_r;
    end else if (bus.addr == irq_regs_pkg::OFF_LVL1) begin
      rdata_nxt = lvl1_r;
    end else if (bus.addr == irq_regs_pkg::OFF_FLAG) begin
      rdata_nxt = flag_sync_r[15:0];
    end else if (bus.addr == irq_regs_pkg::OFF_FLAGHI) begin
      rdata_nxt = flag_sync_r[95:80];
    end else if (bus.addr == irq_regs_pkg::OFF_STAT) begin
      rdata_nxt = {14'h0000, stat_r};
    end else if (bus.addr == irq_regs_pkg::OFF_MASK) begin
      rdata_nxt = {14'h0000, mask_r};
    end else if (bus.addr == irq_regs_pkg::OFF_VARIANT) begin
      rdata_nxt = {15'h0000, can_sync_r};
    end
  end

  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdata_out <= '0;
    end else if (bus.rd) begin
      rdata_out <= rdata_nxt;
    end else begin
      rdata_out <= '0;
    end
  end

  // unused named views of the raw enable bits, taken before the can gating, kept for debug
  logic can_any_en;
  assign can_any_en = can_event_en | can_rx_data_en | can_tx_data_en |
                      i2c_a_master_evt_en | i2c_a_slave_evt_en;

endmodule

// *** hdl/irq_regs_pkg.sv ***
// package: register map, field layouts and reset values for the interrupt enable/level block
package irq_regs_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // register offsets (word indices)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_EN2    = 5'h00;
  localparam logic [4:0] OFF_EN3    = 5'h01;
  localparam logic [4:0] OFF_EN4    = 5'h02;
  localparam logic [4:0] OFF_EN5    = 5'h03;
  localparam logic [4:0] OFF_EN6    = 5'h04;
  localparam logic [4:0] OFF_EN7    = 5'h05;
  localparam logic [4:0] OFF_LVL0   = 5'h06;
  localparam logic [4:0] OFF_LVL1   = 5'h07;
  localparam logic [4:0] OFF_FLAG   = 5'h08;
  localparam logic [4:0] OFF_FLAGHI = 5'h09;
  localparam logic [4:0] OFF_STAT   = 5'h0A;
  localparam logic [4:0] OFF_MASK   = 5'h0B;
  localparam logic [4:0] OFF_VARIANT = 5'h0C;

  // ----------------------------------------------------------------
  // writable bit masks of each enable word and of the level words
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_EN2 = 16'h007F;
  localparam logic [15:0] MASK_EN3 = 16'h0666;
  localparam logic [15:0] MASK_EN4 = 16'h0A46;
  localparam logic [15:0] MASK_EN5 = 16'hE000;
  localparam logic [15:0] MASK_EN6 = 16'hC38F;
  localparam logic [15:0] MASK_EN7 = 16'h003F;
  localparam logic [15:0] MASK_LVL = 16'h7777;

  // can bits that die on variants without the can controller
  localparam logic [15:0] CAN_EN2  = 16'h000C;
  localparam logic [15:0] CAN_EN4  = 16'h0040;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_EN   = 16'h0000;
  localparam logic [15:0] RST_LVL  = 16'h4444;
  localparam logic [2:0]  LVL_OFF  = 3'h0;

  // ----------------------------------------------------------------
  // source bookkeeping
  // ----------------------------------------------------------------
  localparam int NUM_EN_WORDS = 6;
  localparam int NUM_EN_SRC   = NUM_EN_WORDS * DATA_W;
  localparam int NUM_LVL_SRC  = 8;

  // status event bits
  localparam int EVT_REQ_RISE = 0;
  localparam int EVT_BLOCKED  = 1;
  localparam int EVT_W        = 2;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic       req;
    logic [2:0] level;
  } lvl_req_t;

endpackage

// *** hdl/level_gate.sv ***
// file: one source's priority gate, level field plus flag plus enable
`timescale 1ns/100ps
module level_gate (
  input  wire logic       flag_in,
  input  wire logic       en_in,
  input  wire logic [2:0] level_in,
  output irq_regs_pkg::lvl_req_t req_out
);

  // --------------------------------------------------------------
  // gating
  // --------------------------------------------------------------
  always_comb begin
    // level zero kills the source whatever the enable holds
    req_out.req   = flag_in && en_in && (level_in != irq_regs_pkg::LVL_OFF);
    req_out.level = req_out.req ? level_in : irq_regs_pkg::LVL_OFF;
  end

endmodule

// *** tb/irq_enable_level_regs_monitor.sv ***
// checker: concurrent properties on the enable and level register block
`timescale 1ns/100ps
module irq_enable_level_regs_monitor (
  input wire logic        mclk_in,
  input wire logic        rstn_in,
  input wire logic        can_present_in,
  input wire logic [4:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [95:0] src_flag_in,
  input wire logic [15:0] rdata_out,
  input wire logic [95:0] en_req_out,
  input wire logic [7:0]  lvl_req_out,
  input wire logic [23:0] lvl_out,
  input wire logic        irq_out
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  localparam logic [95:0] EN_ALL = {irq_regs_pkg::MASK_EN7, irq_regs_pkg::MASK_EN6,
    irq_regs_pkg::MASK_EN5, irq_regs_pkg::MASK_EN4, irq_regs_pkg::MASK_EN3,
    irq_regs_pkg::MASK_EN2};
  localparam logic [95:0] CAN_POS = {48'h0, irq_regs_pkg::CAN_EN4, 16'h0000,
    irq_regs_pkg::CAN_EN2};
  logic lvl_bad;
  always_comb begin
    lvl_bad = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (lvl_req_out[k] != (lvl_out[3*k +: 3] != 3'h0)) begin
        lvl_bad = 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data not zero outside read slot");
  a_unmapped_read_zero: assert property (rd_in && addr_in > irq_regs_pkg::OFF_VARIANT
    |=> rdata_out == 16'h0000) else $error("unmapped read not zero");
  a_en_unimpl_quiet: assert property ((en_req_out & ~EN_ALL) == 96'h0)
    else $error("request on unimplemented enable bit");
  a_req_needs_flag: assert property ((en_req_out & ~$past(src_flag_in, 3)) == 96'h0)
    else $error("request without flag");
  a_lvl_needs_flag: assert property ((lvl_req_out & ~$past(src_flag_in[87:80], 3)) == 8'h00)
    else $error("level request without flag");
  a_lvl_zero_off: assert property (!lvl_bad)
    else $error("level request and level field disagree");
  a_can_absent_off: assert property (!can_present_in [*5] |-> (en_req_out & CAN_POS) == 96'h0)
    else $error("can request without can controller");
  a_irq_mask_off: assert property (wr_in && addr_in == irq_regs_pkg::OFF_MASK
    && wdata_in == 16'h0000 |-> ##3 !irq_out) else $error("interrupt with mask cleared");
  c_irq_seen: cover property (irq_out);
  c_i2c_req: cover property ($rose(en_req_out[1]));
  c_lvl_top: cover property (lvl_req_out[3] && lvl_out[11:9] == 3'h7);
endmodule
bind irq_enable_level_regs irq_enable_level_regs_monitor u_mon (.mclk_in(mclk_in),
  .rstn_in(rstn_in), .can_present_in(can_present_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .src_flag_in(src_flag_in),
  .rdata_out(rdata_out), .en_req_out(en_req_out), .lvl_req_out(lvl_req_out),
  .lvl_out(lvl_out), .irq_out(irq_out));

// *** tb/interrupt_enable_priority_regs_tb.sv ***
// testbench: scenario tasks for the enable and level register block
`timescale 1ns/100ps
module interrupt_enable_priority_regs_tb;
  // ----------------------------------------------------------------
  // signals and instance
  // ----------------------------------------------------------------
  logic        mclk_in;
  logic        rstn_in;
  logic        can_present_in;
  logic [4:0]  addr_in;
  logic [15:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [95:0] src_flag_in;
  logic [15:0] rdata_out;
  logic [95:0] en_req_out;
  logic [7:0]  lvl_req_out;
  logic [23:0] lvl_out;
  logic        irq_out;
  logic [15:0] d;
  int          bad_count;
  int          check_count;
  localparam logic [95:0] CAN_POS = {48'h0, irq_regs_pkg::CAN_EN4, 16'h0000,
    irq_regs_pkg::CAN_EN2};
  logic [15:0] m [6] = '{irq_regs_pkg::MASK_EN2, irq_regs_pkg::MASK_EN3,
    irq_regs_pkg::MASK_EN4, irq_regs_pkg::MASK_EN5, irq_regs_pkg::MASK_EN6,
    irq_regs_pkg::MASK_EN7};
  irq_enable_level_regs dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .can_present_in(can_present_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .src_flag_in(src_flag_in), .rdata_out(rdata_out),
    .en_req_out(en_req_out), .lvl_req_out(lvl_req_out), .lvl_out(lvl_out),
    .irq_out(irq_out));
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 6; i++) begin
      rd(5'(i));
      chk("enable reset", 96'h0, 96'(d));
      wr(5'(i), 16'hFFFF);
      rd(5'(i));
      chk("enable bits", 96'(m[i]), 96'(d));
    end
    rd(irq_regs_pkg::OFF_LVL1);
    chk("level reset", 96'h4444, 96'(d));
    wr(irq_regs_pkg::OFF_LVL0, 16'hFFFF);
    rd(irq_regs_pkg::OFF_LVL0);
    chk("level bits", 96'h7777, 96'(d));
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F);
    chk("unmapped", 96'h0, 96'(d));
  endtask
  task automatic t_gate;
    @(posedge mclk_in);
    src_flag_in <= '1;
    settle(5);
    chk("requests", {m[5], m[4], m[3], m[2], m[1], m[0]}, en_req_out);
    wr(irq_regs_pkg::OFF_EN3, 16'h0000);
    settle(3);
    chk("word off", {m[5], m[4], m[3], m[2], 16'h0, m[0]}, en_req_out);
    @(posedge mclk_in);
    can_present_in <= 1'b0;
    settle(6);
    chk("can absent", 96'h0, en_req_out & CAN_POS);
    @(posedge mclk_in);
    can_present_in <= 1'b1;
    settle(6);
    chk("can present", CAN_POS, en_req_out & CAN_POS);
    rd(irq_regs_pkg::OFF_VARIANT);
    chk("variant", 96'h1, 96'(d));
    wr(irq_regs_pkg::OFF_EN2, 16'h0002);
    settle(3);
    chk("master bit", 96'h2, 96'(en_req_out[15:0]));
    wr(irq_regs_pkg::OFF_EN2, 16'h0001);
    settle(3);
    chk("slave bit", 96'h1, 96'(en_req_out[15:0]));
  endtask
  task automatic t_level;
    wr(irq_regs_pkg::OFF_LVL0, 16'h7010);
    settle(3);
    chk("level reqs", 96'hFA, 96'(lvl_req_out));
    chk("levels", 96'h924E08, 96'(lvl_out));
    @(posedge mclk_in);
    src_flag_in[87:80] <= 8'h00;
    settle(5);
    chk("level flags", 96'h0, 96'(lvl_req_out));
  endtask
  task automatic t_irq;
    @(posedge mclk_in);
    src_flag_in <= '0;
    wr(irq_regs_pkg::OFF_EN2, 16'h0002);
    settle(5);
    wr(irq_regs_pkg::OFF_STAT, 16'h0003);
    wr(irq_regs_pkg::OFF_MASK, 16'h0001);
    settle(3);
    chk("irq idle", 96'h0, 96'(irq_out));
    @(posedge mclk_in);
    src_flag_in[1] <= 1'b1;
    settle(6);
    chk("irq raised", 96'h1, 96'(irq_out));
    rd(irq_regs_pkg::OFF_FLAG);
    chk("flag read", 96'h2, 96'(d));
    rd(irq_regs_pkg::OFF_STAT);
    chk("status", 96'h1, 96'(d[0]));
    wr(irq_regs_pkg::OFF_MASK, 16'h0000);
    settle(4);
    chk("irq masked", 96'h0, 96'(irq_out));
    wr(irq_regs_pkg::OFF_MASK, 16'h0001);
    wr(irq_regs_pkg::OFF_STAT, 16'h0001);
    settle(3);
    chk("irq cleared", 96'h0, 96'(irq_out));
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rstn_in = 1'b0;
    can_present_in = 1'b1;
    addr_in = 5'h00;
    wdata_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    src_flag_in = '0;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    t_regs;
    t_gate;
    t_level;
    t_irq;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge mclk_in);
    bad_count++;
    conclude;
  end
endmodule
